// file: dv/bt_usb_compound_device_test.sv
`timescale 1ns/1ps
module bt_usb_compound_device_test;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, nv_valid, bus_activity, bus_suspend, wake_allowed, tok_valid;
   logic setup_valid, hub_mode, self_powered, full_speed, usb_transport, boot_hid;
   logic dfu_enabled, suspended, resume_drive, std_ack, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr, tok_ep;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, setup_func;
   logic [2:0] port_suspend, port_connected, port_is_hid, conn, ps;
   usbc_pkg::cfg_type nv_cfg;
   usbc_pkg::desc_type nv_desc, desc_out;
   usbc_pkg::ep_info_type ep_info;
   int failures = 0;
   int total_checks = 0;
   logic [33:0] rq[$];
   logic [1:0] wq[$];
   logic [7:0] eps[9] = '{8'h00, 8'h81, 8'h82, 8'h02, 8'h83, 8'h03, 8'h84, 8'h04, 8'h85};
   logic hub;
   int n;

   usb_compound_ctrl #(.NUM_PORTS(3), .NUM_ALT(6), .RESUME_CYCLES(8)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .nv_valid(nv_valid), .nv_cfg(nv_cfg), .nv_desc(nv_desc),
      .bus_activity(bus_activity), .bus_suspend(bus_suspend), .port_suspend(port_suspend),
      .wake_allowed(wake_allowed), .tok_valid(tok_valid), .tok_ep(tok_ep),
      .setup_valid(setup_valid), .setup_func(setup_func), .desc_out(desc_out),
      .hub_mode(hub_mode), .port_connected(port_connected), .port_is_hid(port_is_hid),
      .self_powered(self_powered), .full_speed(full_speed), .usb_transport(usb_transport),
      .boot_hid(boot_hid), .dfu_enabled(dfu_enabled), .suspended(suspended),
      .resume_drive(resume_drive), .ep_info(ep_info), .std_ack(std_ack), .irq(irq));

   usb_host_model i_host (
      .aclk(aclk), .bus_activity(bus_activity), .bus_suspend(bus_suspend),
      .port_suspend(port_suspend), .wake_allowed(wake_allowed), .tok_valid(tok_valid),
      .tok_ep(tok_ep), .setup_valid(setup_valid), .setup_func(setup_func));

   // Clock, 25 ns period
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic finish_test();
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // A bounded wait that ran dry ends the run
   task automatic give_up();
      failures++;
      $display("unexpected at %0t: wait limit reached", $time);
      finish_test();
   endtask

   // Responses are compared in arrival order against the driver's notes
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0) begin
         check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      end
      if (s_axi_bvalid && s_axi_bready && wq.size() > 0) begin
         check(34'(s_axi_bresp), 34'(wq.pop_front()));
      end
   end

   // Address and data offered together, held until the answer edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      wq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!(s_axi_awready && s_axi_wready && s_axi_bvalid) && n < 50);
      if (n >= 50) give_up();
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      rq.push_back({r, d});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!(s_axi_arready && s_axi_rvalid) && n < 50);
      if (n >= 50) give_up();
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
   endtask

   task automatic waitc(input int c);
      repeat (c) @(posedge aclk);
      #1;
   endtask

   // Endpoint map as the host should see it
   function automatic logic [4:0] ep_exp(input logic [7:0] ep, input logic alt_on);
      case (ep)
         8'h00: ep_exp = {1'b1, 2'd0, usbc_pkg::TT_CTRL};
         8'h81: ep_exp = {1'b1, 2'd0, usbc_pkg::TT_INT};
         8'h82, 8'h02: ep_exp = {1'b1, 2'd0, usbc_pkg::TT_BULK};
         // Alternate 0 keeps the map but marks the endpoint unusable
         8'h83, 8'h03: ep_exp = {alt_on, 2'd1, usbc_pkg::TT_ISO};
         8'h84, 8'h04: ep_exp = {1'b1, 2'd2, usbc_pkg::TT_BULK};
         default: ep_exp = 5'h00;
      endcase
   endfunction

   initial begin
      void'($urandom(32'hce2a6a9c));
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      nv_valid = 1'b0;
      nv_cfg = 7'h00;
      nv_desc = 32'h0000_0000;
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      waitc(2);
      check(34'(desc_out), 34'(usbc_pkg::DESC_RST));
      check(34'({hub_mode, port_connected, full_speed}), 34'h1);
      rd(usbc_pkg::OFS_CTRL, 32'(usbc_pkg::CFG_RST), usbc_pkg::RESP_OK);
      rd(8'h1c, 32'h0, usbc_pkg::RESP_SLVERR);
      wr(8'h02, 32'h0000_0001, usbc_pkg::RESP_SLVERR);
      // Boot from the stored record: hub, mouse, Bluetooth, extras on
      @(posedge aclk);
      nv_cfg <= 7'h7b;
      nv_desc <= $urandom();
      nv_valid <= 1'b1;
      @(posedge aclk);
      nv_valid <= 1'b0;
      waitc(5);
      check(34'(desc_out), 34'(nv_desc));
      check(34'({hub_mode, port_connected}), 34'hd);
      check(34'({self_powered, dfu_enabled, boot_hid}), 34'h7);
      check(34'({port_is_hid[2], port_is_hid[0]}), 34'h1);
      rd(usbc_pkg::OFS_DESC, nv_desc, usbc_pkg::RESP_OK);
      // Every hub, mouse and keyboard combination via reboot
      for (int i = 0; i < 8; i++) begin
         ps = 3'($urandom());
         hub = i[0];
         conn = hub ? {ps[0], i[2], i[1]} : 3'h0;
         wr(usbc_pkg::OFS_CTRL, {24'h0, 1'b1, 3'h0, ps[0], i[2:0]}, usbc_pkg::RESP_OK);
         wr(usbc_pkg::OFS_ALT, 32'(i[1] ? 5 : 0), usbc_pkg::RESP_OK);
         waitc(5);
         check(34'(hub_mode), 34'(hub));
         check(34'(port_connected), 34'(conn));
         for (int f = 0; f < 3; f++) begin
            i_host.setup(2'(f));
            #1;
            check(34'(std_ack), 34'(hub ? conn[f] : (f == 2)));
         end
         foreach (eps[e]) begin
            i_host.token(eps[e]);
            waitc(2);
            check(34'(ep_info), 34'(ep_exp(eps[e], i[1])));
         end
      end
      wr(usbc_pkg::OFS_ALT, 32'h6, usbc_pkg::RESP_OK);
      rd(usbc_pkg::OFS_ALT, 32'h5, usbc_pkg::RESP_OK);
      // Activity, then masked suspend interrupt
      i_host.lines(1'b1, 1'b0, 3'h0, 1'b0);
      waitc(3);
      check(34'(usb_transport), 34'h1);
      wr(usbc_pkg::OFS_MASK, 32'h0, usbc_pkg::RESP_OK);
      wr(usbc_pkg::OFS_IRQ, 32'h1f, usbc_pkg::RESP_OK);
      waitc(3);
      check(34'(irq), 34'h0);
      wr(usbc_pkg::OFS_MASK, 32'h2, usbc_pkg::RESP_OK);
      i_host.lines(1'b1, 1'b1, ps, 1'b0);
      waitc(4);
      check(34'({suspended, irq}), 34'h3);
      rd(usbc_pkg::OFS_IRQ, 32'h2, usbc_pkg::RESP_OK);
      rd(usbc_pkg::OFS_STAT, {20'h0, 3'b010, ps, 1'b1, conn, hub, 1'b1}, usbc_pkg::RESP_OK);
      wr(usbc_pkg::OFS_IRQ, 32'h2, usbc_pkg::RESP_OK);
      waitc(3);
      check(34'(irq), 34'h0);
      // Remote wake: resume driven for the set count
      wr(usbc_pkg::OFS_WAKE, 32'h1, usbc_pkg::RESP_OK);
      i_host.lines(1'b1, 1'b1, 3'h0, 1'b1);
      n = 0;
      while (!resume_drive && n < 100) begin
         @(posedge aclk);
         n++;
      end
      if (n >= 100) give_up();
      n = 0;
      while (resume_drive && n < 100) begin
         @(posedge aclk);
         n++;
      end
      check(34'(n), 34'd8);
      i_host.lines(1'b1, 1'b0, 3'h0, 1'b0);
      waitc(4);
      check(34'(suspended), 34'h0);
      // Suspend re-entered after the wake, then left by the host
      rd(usbc_pkg::OFS_IRQ, 32'h6, usbc_pkg::RESP_OK);
      waitc(2);
      finish_test();
   end
endmodule

// file: dv/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
   // Clock
   input wire logic aclk,
   // Bus state toward the function logic
   output logic bus_activity,
   output logic bus_suspend,
   output logic [2:0] port_suspend,
   output logic wake_allowed,
   // Token and setup strobes
   output logic tok_valid,
   output logic [7:0] tok_ep,
   output logic setup_valid,
   output logic [1:0] setup_func
);
   // Quiet bus at power-up
   initial begin
      bus_activity = 1'b0;
      bus_suspend = 1'b0;
      port_suspend = 3'h0;
      wake_allowed = 1'b0;
      tok_valid = 1'b0;
      tok_ep = 8'h00;
      setup_valid = 1'b0;
      setup_func = 2'h0;
   end
   // Levels change just after an edge
   task automatic lines(input logic act, input logic susp, input logic [2:0] ps,
                        input logic wk);
      @(posedge aclk);
      bus_activity <= act;
      bus_suspend <= susp;
      port_suspend <= ps;
      wake_allowed <= wk;
   endtask
   // One token; debug endpoints only when a test names them
   task automatic token(input logic [7:0] ep);
      @(posedge aclk);
      tok_valid <= 1'b1;
      tok_ep <= ep;
      @(posedge aclk);
      tok_valid <= 1'b0;
      tok_ep <= ~ep; // Stale address must not be relied on
   endtask
   // One standard request to an internal function
   task automatic setup(input logic [1:0] f);
      @(posedge aclk);
      setup_valid <= 1'b1;
      setup_func <= f;
      @(posedge aclk);
      setup_valid <= 1'b0;
      setup_func <= ~f;
   endtask
endmodule

// file: hw/usb_compound_ctrl.sv
// What this block does
// - Boot as single device or hub
// - Hub exposes up to three connected ports
// - Ports 1,2 lite HID, port 3 Bluetooth
// - Interface 0: control, ACL, event endpoints
// - Interface 1: isochronous SCO, alternate settings
// - Interface 2: debug bulk endpoints, always mapped
// - Same three interfaces in both modes
// - Mouse or keyboard needs hub enabled
// - Descriptors programmable, loaded from NVRAM
// - Each internal device enabled by record
// - Bus activity selects USB transport
// - Everything runs at full speed
// - Global, selective suspend; remote wake-up
// - Bus or self power, dynamic config
// - HID, DFU and boot-time HID emulation
// - Emulated HID looks directly attached
// - Hub mode answers standard requests itself
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module usb_compound_ctrl #(
   parameter int NUM_PORTS = 3,
   parameter int NUM_ALT = 6,
   parameter int RESUME_CYCLES = usbc_pkg::RESUME_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // NVRAM configuration record
   input wire logic nv_valid,
   input wire usbc_pkg::cfg_type nv_cfg,
   input wire usbc_pkg::desc_type nv_desc,
   // USB function engine side
   input wire logic bus_activity,
   input wire logic bus_suspend,
   input wire logic [NUM_PORTS-1:0] port_suspend,
   input wire logic wake_allowed,
   input wire logic tok_valid,
   input wire logic [7:0] tok_ep,
   input wire logic setup_valid,
   input wire logic [1:0] setup_func,
   // Status toward the function engine
   output usbc_pkg::desc_type desc_out,
   output logic hub_mode,
   output logic [NUM_PORTS-1:0] port_connected,
   output logic [NUM_PORTS-1:0] port_is_hid,
   output logic self_powered,
   output logic full_speed,
   output logic usb_transport,
   output logic boot_hid,
   output logic dfu_enabled,
   output logic suspended,
   output logic resume_drive,
   output usbc_pkg::ep_info_type ep_info,
   output logic std_ack,
   output logic irq
);
   usbc_pkg::cfg_type cfg_ff;
   usbc_pkg::cfg_type live_ff;
   usbc_pkg::desc_type desc_ff;
   usbc_pkg::pm_state_type pm_ff;
   usbc_pkg::ep_info_type ep_ff;
   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic hub_ff, xport_ff, susp_ff, drive_ff, ack_ff, irq_ff, fs_ff;
   logic [NUM_PORTS-1:0] conn_ff, hid_ff;
   logic [usbc_pkg::IRQ_W-1:0] stat_ff, mask_ff, nxt_stat;
   logic [2:0] alt_ff;
   logic [31:0] wake_cnt_ff;
   logic act_seen_ff, wake_req_ff;
   logic wr_go, rd_go, reboot, boot, hit_w, hit_r;
   logic [31:0] rd_val;
   logic [NUM_PORTS-1:0] en_vec;
   // Write takes address and data together, read is separate
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff && !awready_ff;
   assign rd_go = s_axi_arvalid && !rvalid_ff && !arready_ff;
   assign hit_w = (s_axi_awaddr <= usbc_pkg::OFS_ALT) && (s_axi_awaddr[1:0] == 2'h0);
   assign hit_r = (s_axi_araddr <= usbc_pkg::OFS_ALT) && (s_axi_araddr[1:0] == 2'h0);
   assign reboot = wr_go && s_axi_awaddr == usbc_pkg::OFS_CTRL && s_axi_wstrb[0]
      && s_axi_wdata[usbc_pkg::CTRL_REBOOT_BIT];
   // Boot latch fires on an NVRAM record or a soft reboot
   assign boot = nv_valid || reboot;
   // AXI handshake, one-cycle ready pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= usbc_pkg::RESP_OK;
      end else begin
         awready_ff <= wr_go;
         wready_ff <= wr_go;
         if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= hit_w ? usbc_pkg::RESP_OK : usbc_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end
   // Read mux; status shows the block's own state plus the live port_suspend input
   always_comb begin
      rd_val = 32'h0000_0000;
      case (s_axi_araddr)
         usbc_pkg::OFS_CTRL: rd_val = {25'h0, cfg_ff};
         usbc_pkg::OFS_DESC: rd_val = desc_ff;
         usbc_pkg::OFS_STAT: rd_val = {20'h0, pm_ff, port_suspend, xport_ff, conn_ff,
            hub_ff, fs_ff};
         usbc_pkg::OFS_IRQ: rd_val = {27'h0, stat_ff};
         usbc_pkg::OFS_MASK: rd_val = {27'h0, mask_ff};
         usbc_pkg::OFS_WAKE: rd_val = {31'h0, wake_req_ff};
         usbc_pkg::OFS_ALT: rd_val = {29'h0, alt_ff};
         default: rd_val = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= usbc_pkg::RESP_OK;
      end else begin
         arready_ff <= rd_go;
         if (rd_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_val;
            rresp_ff <= hit_r ? usbc_pkg::RESP_OK : usbc_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end
   // Programmable configuration and descriptors; NVRAM record wins a tie
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff <= usbc_pkg::CFG_RST;
         desc_ff <= usbc_pkg::DESC_RST;
      end else if (nv_valid) begin
         cfg_ff <= nv_cfg;
         desc_ff <= nv_desc;
      end else if (wr_go) begin
         if (s_axi_awaddr == usbc_pkg::OFS_CTRL && s_axi_wstrb[0])
            cfg_ff <= s_axi_wdata[6:0];
         if (s_axi_awaddr == usbc_pkg::OFS_DESC) begin
            for (int b = 0; b < 4; b++) begin
               if (s_axi_wstrb[b])
                  desc_ff[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
            end
         end
      end
   end
   // Per-port enables; HID ports need the hub
   assign en_vec = {live_ff.bt_en, live_ff.kbd_en, live_ff.mouse_en};
   // Session latch: mode and port presence only move at a boot
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         live_ff <= usbc_pkg::CFG_RST;
         hub_ff <= 1'b0;
         conn_ff <= '0;
      end else begin
         // A soft reboot takes the word being written, not the old CTRL
         if (nv_valid)
            live_ff <= nv_cfg;
         else if (reboot)
            live_ff <= s_axi_wdata[6:0];
         hub_ff <= live_ff.hub_en;
         for (int p = 0; p < NUM_PORTS; p++) begin
            // Lite HID cores need the hub, otherwise nothing appears
            conn_ff[p] <= live_ff.hub_en && en_vec[p];
         end
      end
   end
   // Port roles: lite HID cores on ports 1 and 2, full core on 3
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hid_ff <= '0;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            hid_ff[p] <= (p != usbc_pkg::PORT_BT) && conn_ff[p];
         end
      end
   end
   // Full speed is the only speed offered, high from the first edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fs_ff <= 1'b0;
      end else begin
         fs_ff <= 1'b1;
      end
   end
   // Transport latches on first bus activity and stays
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         xport_ff <= 1'b0;
         act_seen_ff <= 1'b0;
      end else begin
         act_seen_ff <= bus_activity;
         if (bus_activity)
            xport_ff <= 1'b1;
      end
   end
   // Suspend and remote wake state machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pm_ff <= usbc_pkg::ST_ACTIVE;
         wake_cnt_ff <= 32'h0000_0000;
         wake_req_ff <= 1'b0;
         drive_ff <= 1'b0;
         susp_ff <= 1'b0;
      end else begin
         if (wr_go && s_axi_awaddr == usbc_pkg::OFS_WAKE && s_axi_wstrb[0])
            wake_req_ff <= s_axi_wdata[0];
         case (pm_ff)
            usbc_pkg::ST_ACTIVE: begin
               if (bus_suspend) begin
                  pm_ff <= usbc_pkg::ST_SUSP;
                  susp_ff <= 1'b1;
               end
            end
            usbc_pkg::ST_SUSP: begin
               if (!bus_suspend) begin
                  pm_ff <= usbc_pkg::ST_ACTIVE;
                  susp_ff <= 1'b0;
               end else if (wake_req_ff && wake_allowed) begin
                  // Host must have armed wake, else the request waits
                  pm_ff <= usbc_pkg::ST_WAKE;
                  wake_cnt_ff <= 32'(RESUME_CYCLES - 1);
                  drive_ff <= 1'b1;
                  wake_req_ff <= 1'b0;
               end
            end
            usbc_pkg::ST_WAKE: begin
               if (wake_cnt_ff == 32'h0000_0000) begin
                  pm_ff <= usbc_pkg::ST_ACTIVE;
                  drive_ff <= 1'b0;
                  susp_ff <= 1'b0;
               end else begin
                  wake_cnt_ff <= wake_cnt_ff - 32'h0000_0001;
               end
            end
            default: begin
               pm_ff <= usbc_pkg::ST_ACTIVE;
               drive_ff <= 1'b0;
               susp_ff <= 1'b0;
            end
         endcase
      end
   end
   // Alternate setting of the SCO interface, writes beyond what exists are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alt_ff <= 3'h0;
      end else if (wr_go && s_axi_awaddr == usbc_pkg::OFS_ALT && s_axi_wstrb[0]
         && 32'(s_axi_wdata[2:0]) < NUM_ALT) begin
         alt_ff <= s_axi_wdata[2:0];
      end
   end
   // Endpoint map; identical in both modes, only the SCO alternate setting gates it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep_ff <= usbc_pkg::EP_NONE;
      end else if (tok_valid) begin
         case (tok_ep)
            usbc_pkg::EP_CTRL: ep_ff <= {1'b1, 2'h0, usbc_pkg::TT_CTRL};
            usbc_pkg::EP_EVT_IN: ep_ff <= {1'b1, 2'h0, usbc_pkg::TT_INT};
            usbc_pkg::EP_ACL_IN, usbc_pkg::EP_ACL_OUT:
               ep_ff <= {1'b1, 2'h0, usbc_pkg::TT_BULK};
            // Alternate 0 reserves no isochronous bandwidth
            usbc_pkg::EP_SCO_IN, usbc_pkg::EP_SCO_OUT:
               ep_ff <= {alt_ff != 3'h0, 2'h1, usbc_pkg::TT_ISO};
            usbc_pkg::EP_DBG_IN, usbc_pkg::EP_DBG_OUT:
               ep_ff <= {1'b1, 2'h2, usbc_pkg::TT_BULK};
            default: ep_ff <= usbc_pkg::EP_NONE;
         endcase
      end
   end
   // Standard requests answered for every present function
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= setup_valid && (setup_func < 2'(NUM_PORTS))
            && (hub_ff ? conn_ff[setup_func] : (setup_func == 2'(usbc_pkg::PORT_BT)));
      end
   end
   // Sticky status, set wins over write-one-to-clear
   always_comb begin
      nxt_stat = stat_ff;
      if (wr_go && s_axi_awaddr == usbc_pkg::OFS_IRQ && s_axi_wstrb[0])
         nxt_stat = stat_ff & ~s_axi_wdata[usbc_pkg::IRQ_W-1:0];
      if (bus_activity && !act_seen_ff)
         nxt_stat[usbc_pkg::IRQ_ACT] = 1'b1;
      if (bus_suspend && pm_ff == usbc_pkg::ST_ACTIVE)
         nxt_stat[usbc_pkg::IRQ_SUSP] = 1'b1;
      if (pm_ff == usbc_pkg::ST_SUSP && !bus_suspend)
         nxt_stat[usbc_pkg::IRQ_RESUME] = 1'b1;
      if (boot)
         nxt_stat[usbc_pkg::IRQ_BOOT] = 1'b1;
      if (ack_ff)
         nxt_stat[usbc_pkg::IRQ_STDREQ] = 1'b1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_ff <= '0;
         mask_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
         if (wr_go && s_axi_awaddr == usbc_pkg::OFS_MASK && s_axi_wstrb[0])
            mask_ff <= s_axi_wdata[usbc_pkg::IRQ_W-1:0];
         irq_ff <= |(stat_ff & mask_ff);
      end
   end
   // Outputs straight from flops
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rdata_ff;
   assign s_axi_rresp = rresp_ff;
   assign desc_out = desc_ff;
   assign hub_mode = hub_ff;
   assign port_connected = conn_ff;
   assign port_is_hid = hid_ff;
   assign self_powered = live_ff.self_pwr;
   assign full_speed = fs_ff;
   assign usb_transport = xport_ff;
   assign boot_hid = live_ff.hid_emulation;
   assign dfu_enabled = live_ff.dfu_en;
   assign suspended = susp_ff;
   assign resume_drive = drive_ff;
   assign ep_info = ep_ff;
   assign std_ack = ack_ff;
   assign irq = irq_ff;

   // Checks
   sequence wake_start_s;
      pm_ff == usbc_pkg::ST_SUSP && bus_suspend && wake_req_ff && wake_allowed;
   endsequence
   sequence drive_on_s;
      drive_ff && pm_ff == usbc_pkg::ST_WAKE;
   endsequence
   hid_needs_hub_a: assert property (@(posedge aclk) disable iff (!aresetn)
      |conn_ff[1:0] |-> hub_ff) else $error("HID port shown without hub");
   session_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !boot && !$past(boot) && $past(aresetn) |=> $stable(live_ff))
      else $error("Port record changed outside boot");
   bt_port_a: assert property (@(posedge aclk) disable iff (!aresetn)
      hid_ff[usbc_pkg::PORT_BT] == 1'b0) else $error("BT port flagged HID");
   remote_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wake_start_s |=> drive_on_s [*2]) else $error("Resume drive missing");
   transport_a: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_activity |=> xport_ff ##1 xport_ff) else $error("Transport not selected");
   sco_alt_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tok_valid && tok_ep == usbc_pkg::EP_SCO_IN |=> ep_ff.ok == ($past(alt_ff) != 3'h0))
      else $error("SCO endpoint gating wrong");
   debug_ep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tok_valid && tok_ep == usbc_pkg::EP_DBG_OUT |=> ep_ff.ok && ep_ff.iface == 2'h2)
      else $error("Debug endpoint not mapped");
   std_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
      setup_valid && hub_ff && setup_func == 2'h2 && conn_ff[2] |=> std_ack)
      else $error("Standard request not answered");
   nv_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      nv_valid |=> desc_ff == $past(nv_desc) ##1 live_ff == $past(nv_cfg, 2))
      else $error("NVRAM record not taken");
   irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
      |(stat_ff & mask_ff) |=> irq) else $error("Interrupt not raised");
endmodule

// file: hw/usbc_pkg.sv
package usbc_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DESC = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ = 8'h0c;
   localparam logic [7:0] OFS_MASK = 8'h10;
   localparam logic [7:0] OFS_WAKE = 8'h14;
   localparam logic [7:0] OFS_ALT = 8'h18;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // CTRL bit 7 written as one re-runs the boot latch
   localparam int CTRL_REBOOT_BIT = 7;
   // Configuration record, same layout in NVRAM and in CTRL[6:0]
   typedef struct packed {
      logic dfu_en;
      logic hid_emulation;
      logic self_pwr;
      logic bt_en;
      logic kbd_en;
      logic mouse_en;
      logic hub_en;
   } cfg_type;
   localparam cfg_type CFG_RST = 7'h08;
   // Descriptor identifiers
   typedef struct packed {
      logic [15:0] pid;
      logic [15:0] vid;
   } desc_type;
   // Arbitrary neutral identifiers
   localparam desc_type DESC_RST = 32'h0002_0001;
   // Endpoint addresses
   localparam logic [7:0] EP_CTRL = 8'h00;
   localparam logic [7:0] EP_EVT_IN = 8'h81;
   localparam logic [7:0] EP_ACL_IN = 8'h82;
   localparam logic [7:0] EP_ACL_OUT = 8'h02;
   localparam logic [7:0] EP_SCO_IN = 8'h83;
   localparam logic [7:0] EP_SCO_OUT = 8'h03;
   localparam logic [7:0] EP_DBG_IN = 8'h84;
   localparam logic [7:0] EP_DBG_OUT = 8'h04;
   localparam logic [1:0] TT_CTRL = 2'h0;
   localparam logic [1:0] TT_ISO = 2'h1;
   localparam logic [1:0] TT_BULK = 2'h2;
   localparam logic [1:0] TT_INT = 2'h3;
   typedef struct packed {
      logic ok;
      logic [1:0] iface;
      logic [1:0] ttype;
   } ep_info_type;
   localparam ep_info_type EP_NONE = 5'h00;
   // Interrupt status bits
   localparam int IRQ_ACT = 0;
   localparam int IRQ_SUSP = 1;
   localparam int IRQ_RESUME = 2;
   localparam int IRQ_BOOT = 3;
   localparam int IRQ_STDREQ = 4;
   localparam int IRQ_W = 5;
   localparam int PORT_BT = 2;
   localparam int FULL_SPEED_MBPS = 12;
   // Remote wake resume drive time
   localparam int CLK_PERIOD_NS = 25;
   localparam int RESUME_NS = 1000000;
   localparam int RESUME_CYC = (RESUME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      ST_ACTIVE = 3'b001,
      ST_SUSP = 3'b010,
      ST_WAKE = 3'b100
   } pm_state_type;
endpackage
